// ==== hdl/mec_cfg.svh ====
// constants of the 8-bit execution core: field positions, resets, timing
// assumes 16-bit instruction words and 8-bit data memory words
`ifndef MEC_CFG_SVH
`define MEC_CFG_SVH
// four system clocks per instruction cycle, phases 0..3
`define MEC_PH_FETCH 2'h0
`define MEC_PH_READ 2'h1
`define MEC_PH_EXEC 2'h2
`define MEC_PH_LAST 2'h3
`define MEC_OP_HI 15
`define MEC_OP_LO 11
`define MEC_BIT_HI 10
`define MEC_BIT_LO 8
`define MEC_IMM_BIT 9
`define MEC_MEM_BIT 8
`define MEC_PC_LOW_ADDR 8'h06
`define MEC_TBL_PAGE 3'h7
`define MEC_MISC_HALT 8'h00
`define MEC_MISC_WDT 8'h01
`define MEC_MISC_WDT1 8'h02
`define MEC_MISC_WDT2 8'h03
`define MEC_RST_PC 11'h000
`define MEC_RST_BYTE 8'h00
`define MEC_DEC_LIM 4'h9
`define MEC_DEC_LO 9'h006
`define MEC_DEC_HI 9'h060
`define MEC_STK_DEPTH 8
`endif

// ==== hdl/mec_pkg.sv ====
// types of the 8-bit execution core: sequencer states and opcodes
// assumes mec_cfg.svh for field positions
package mec_pkg;
    typedef enum logic [2:0] {
        st_run = 3'b001,
        st_extra = 3'b010,
        st_halt = 3'b100
    } mec_state_t;
    typedef enum logic [4:0] {
        op_nop = 5'h00, op_xfer_to_acc = 5'h01, op_xfer_to_mem = 5'h02,
        op_xfer_imm = 5'h03, op_add = 5'h04, op_add_carry = 5'h05,
        op_subtract = 5'h06, op_sub_borrow = 5'h07, op_dec_adjust = 5'h08,
        op_and = 5'h09, op_or = 5'h0a, op_xor = 5'h0b, op_complement = 5'h0c,
        op_plus_one = 5'h0d, op_minus_one = 5'h0e, op_rot_right = 5'h0f,
        op_rot_right_c = 5'h10, op_rot_left = 5'h11, op_rot_left_c = 5'h12,
        op_bit_clear = 5'h13, op_bit_set = 5'h14, op_skip_zero = 5'h15,
        op_skip_bit_zero = 5'h16, op_skip_bit_set = 5'h17, op_jump = 5'h18,
        op_call = 5'h19, op_return = 5'h1a, op_table_read = 5'h1b,
        op_misc = 5'h1c
    } mec_op_t;
endpackage

// ==== hdl/mec_core.sv ====
// 8-bit execution core: fetch, data memory access, alu, branch, watchdog
// assumes combinational-read program and data memories on clk_sys_i
// What this block does
// - every instruction cycle is four clocks; most instructions take one
// - jump, call, return and table read take two instruction cycles
// - writing the program counter low byte jumps and costs one extra cycle
// - skip costs one cycle, plus one more when the skip is taken
// - skips test a memory byte or one bit of it
// - call saves return point after itself; plain jump saves nothing
// - transfers: memory to acc, acc to memory, immediate to acc
// - add memory or immediate, optional carry, to acc or memory, four flags
// - subtract memory or immediate, optional borrow, to acc or memory
// - carry records sums above 255 and differences of 0 or more (no borrow)
// - decimal adjust corrects acc into memory, touching only carry
// - and, or, xor with memory or immediate change only zero
// - complement inverts a memory byte into memory or acc, zero only
// - plus or minus one on a memory byte, zero flag only
// - plain rotates wrap the end bit and leave flags alone
// - rotates through carry use carry as ninth bit, carry only
// - bit set and clear change only bit i of a memory byte
// - table read fetches program memory data into data memory
// - halt enters power down; watchdog clearing instructions exist
// - add with carry sums acc, memory byte and carry
// - both pre-clears back to back clear timeout and power-down flags
`timescale 1ns/10ps
`default_nettype none
`include "mec_cfg.svh"
module mec_core (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    output logic [10:0] pmem_addr_o,
    input wire logic [15:0] pmem_data_i,
    output logic [7:0] dmem_addr_o,
    input wire logic [7:0] dmem_rdata_i,
    output logic [7:0] dmem_wdata_o,
    output logic dmem_we_o,
    output logic [7:0] acc_o,
    output logic zero_flag_o,
    output logic carry_flag_o,
    output logic half_carry_flag_o,
    output logic signed_range_exceed_flag_o,
    output logic [7:0] table_high_o,
    output logic power_down_o,
    input wire logic wake_i,
    input wire logic wdt_timeout_i,
    output logic wdt_clear_o,
    output logic timeout_flag_o,
    output logic power_down_flag_o
);
    // ****************************************
    // state and decode
    // ****************************************
    mec_pkg::mec_state_t st_ff, nxt_st;
    mec_pkg::mec_op_t op;
    logic [1:0] ph_ff;
    logic [15:0] ir_ff;
    logic [7:0] md_ff, acc_ff, res, bsel, tblh_ff, dwd_ff, dad_ff;
    logic z_ff, c_ff, hc_ff, sov_ff, c_new, cin, is_sub, imm, dst_m;
    logic [10:0] pc_ff, nxt_pc, tgt, stk_top, alu, pad_ff;
    logic [10:0] stk_ff [0:`MEC_STK_DEPTH-1];
    logic [2:0] sp_ff, bi;
    logic [8:0] d1, d2;
    logic ex, fetch, rd, tload, wr_a, wr_m, upd_z, upd_ar, skip, jump;
    logic push, pop, tbl, halt, w0, w1, w2, wclr, pc_low_hit, extra;
    logic dwe_ff, to_ff, pdf_ff, wclr_ff;
    logic [1:0] pre_ff;

    // sum or difference with nibble carry and signed overflow
    function automatic logic [10:0] arith(input logic [7:0] a,
        input logic [7:0] b, input logic ci, input logic sb);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        bb = sb ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        return {(a[7] == bb[7]) && (s[7] != a[7]), h[4], s};
    endfunction

    assign op = mec_pkg::mec_op_t'(ir_ff[`MEC_OP_HI:`MEC_OP_LO]);
    assign bi = ir_ff[`MEC_BIT_HI:`MEC_BIT_LO];
    assign imm = ir_ff[`MEC_IMM_BIT];
    assign dst_m = ir_ff[`MEC_MEM_BIT] & ~imm;
    assign ex = (st_ff == mec_pkg::st_run) && (ph_ff == `MEC_PH_EXEC);
    assign fetch = (st_ff == mec_pkg::st_run) && (ph_ff == `MEC_PH_FETCH);
    assign rd = (st_ff == mec_pkg::st_run) && (ph_ff == `MEC_PH_READ);
    assign tload = (st_ff == mec_pkg::st_extra) && (ph_ff == `MEC_PH_FETCH)
        && (op == mec_pkg::op_table_read);
    assign is_sub = (op == mec_pkg::op_subtract) || (op == mec_pkg::op_sub_borrow);
    assign bsel = imm ? ir_ff[7:0] : md_ff;
    // carry in is the no-borrow sense
    assign cin = (op == mec_pkg::op_add_carry || op == mec_pkg::op_sub_borrow)
        ? c_ff : is_sub;
    assign stk_top = stk_ff[sp_ff - 3'h1];
    assign d1 = ((acc_ff[3:0] > `MEC_DEC_LIM) || hc_ff)
        ? {1'b0, acc_ff} + `MEC_DEC_LO : {1'b0, acc_ff};
    assign d2 = ((d1[7:4] > `MEC_DEC_LIM) || c_ff || d1[8])
        ? d1 + `MEC_DEC_HI : d1;

    // ****************************************
    // execute decode
    // ****************************************
    always_comb begin
        res = md_ff;
        wr_a = 1'b0;
        wr_m = 1'b0;
        upd_z = 1'b0;
        upd_ar = 1'b0;
        c_new = c_ff;
        skip = 1'b0;
        jump = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        tbl = 1'b0;
        halt = 1'b0;
        w0 = 1'b0;
        w1 = 1'b0;
        w2 = 1'b0;
        tgt = ir_ff[10:0];
        alu = arith(acc_ff, bsel, cin, is_sub);
        case (op)
            mec_pkg::op_xfer_to_acc: wr_a = 1'b1;
            mec_pkg::op_xfer_to_mem: begin
                res = acc_ff;
                wr_m = 1'b1;
            end
            mec_pkg::op_xfer_imm: begin
                res = ir_ff[7:0];
                wr_a = 1'b1;
            end
            mec_pkg::op_add, mec_pkg::op_add_carry,
            mec_pkg::op_subtract, mec_pkg::op_sub_borrow: begin
                res = alu[7:0];
                upd_ar = 1'b1;
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            mec_pkg::op_dec_adjust: begin
                res = d2[7:0];
                c_new = c_ff | d2[8];
                wr_m = 1'b1;
            end
            mec_pkg::op_and, mec_pkg::op_or, mec_pkg::op_xor: begin
                res = (op == mec_pkg::op_and) ? (acc_ff & bsel)
                    : (op == mec_pkg::op_or) ? (acc_ff | bsel) : (acc_ff ^ bsel);
                upd_z = 1'b1;
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            mec_pkg::op_complement, mec_pkg::op_plus_one,
            mec_pkg::op_minus_one: begin
                res = (op == mec_pkg::op_complement) ? ~md_ff
                    : (op == mec_pkg::op_plus_one) ? md_ff + 8'h01 : md_ff - 8'h01;
                upd_z = 1'b1;
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            mec_pkg::op_rot_right, mec_pkg::op_rot_right_c,
            mec_pkg::op_rot_left, mec_pkg::op_rot_left_c: begin
                case (op)
                    mec_pkg::op_rot_right: res = {md_ff[0], md_ff[7:1]};
                    mec_pkg::op_rot_right_c: res = {c_ff, md_ff[7:1]};
                    mec_pkg::op_rot_left: res = {md_ff[6:0], md_ff[7]};
                    default: res = {md_ff[6:0], c_ff};
                endcase
                if (op == mec_pkg::op_rot_right_c) begin
                    c_new = md_ff[0];
                end
                if (op == mec_pkg::op_rot_left_c) begin
                    c_new = md_ff[7];
                end
                wr_m = dst_m;
                wr_a = ~dst_m;
            end
            mec_pkg::op_bit_clear, mec_pkg::op_bit_set: begin
                res[bi] = (op == mec_pkg::op_bit_set);
                wr_m = 1'b1;
            end
            mec_pkg::op_skip_zero: begin
                skip = (md_ff == 8'h00);
                wr_a = ir_ff[`MEC_MEM_BIT];
            end
            mec_pkg::op_skip_bit_zero: skip = ~md_ff[bi];
            mec_pkg::op_skip_bit_set: skip = md_ff[bi];
            // only call saves a return point
            mec_pkg::op_jump: jump = 1'b1;
            mec_pkg::op_call: begin
                jump = 1'b1;
                push = 1'b1;
            end
            mec_pkg::op_return: pop = 1'b1;
            // table read in the extra cycle
            mec_pkg::op_table_read: tbl = 1'b1;
            mec_pkg::op_misc: begin
                halt = (ir_ff[7:0] == `MEC_MISC_HALT);
                w0 = (ir_ff[7:0] == `MEC_MISC_WDT);
                w1 = (ir_ff[7:0] == `MEC_MISC_WDT1);
                w2 = (ir_ff[7:0] == `MEC_MISC_WDT2);
            end
            default: res = md_ff;
        endcase
    end

    // write to the pc low byte becomes a jump
    assign pc_low_hit = wr_m && (ir_ff[7:0] == `MEC_PC_LOW_ADDR);
    // pair must be consecutive, either order
    assign wclr = w0 || (w1 && pre_ff[1]) || (w2 && pre_ff[0]);
    assign extra = jump || skip || pop || tbl || pc_low_hit;

    always_comb begin
        if (skip) begin
            nxt_pc = pc_ff + 11'h002;
        end else if (pc_low_hit) begin
            nxt_pc = {pc_ff[10:8], res};
        end else if (jump) begin
            nxt_pc = tgt;
        end else if (pop) begin
            nxt_pc = stk_top;
        end else begin
            nxt_pc = pc_ff + 11'h001;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            mec_pkg::st_run: begin
                if (ex) begin
                    nxt_st = extra ? mec_pkg::st_extra
                        : halt ? mec_pkg::st_halt : mec_pkg::st_run;
                end
            end
            mec_pkg::st_extra: begin
                if (ph_ff == `MEC_PH_EXEC) begin
                    nxt_st = mec_pkg::st_run;
                end
            end
            mec_pkg::st_halt: begin
                if (wake_i || wdt_timeout_i) begin
                    nxt_st = mec_pkg::st_run;
                end
            end
            default: nxt_st = mec_pkg::st_run;
        endcase
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= mec_pkg::st_run;
            ph_ff <= `MEC_PH_FETCH;
        end else begin
            st_ff <= nxt_st;
            // phase forced to fetch while halted so wake resumes at a fetch
            ph_ff <= (st_ff == mec_pkg::st_halt) ? `MEC_PH_FETCH : ph_ff + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ir_ff <= 16'h0000;
            md_ff <= `MEC_RST_BYTE;
            dad_ff <= `MEC_RST_BYTE;
        end else begin
            if (fetch) begin
                ir_ff <= pmem_data_i;
                dad_ff <= pmem_data_i[7:0];
            end
            if (rd) begin
                md_ff <= dmem_rdata_i;
            end
        end
    end

    // ****************************************
    // accumulator and flags
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_ff <= `MEC_RST_BYTE;
            {z_ff, c_ff, hc_ff, sov_ff} <= 4'h0;
        end else if (ex) begin
            if (wr_a) begin
                acc_ff <= res;
            end
            if (upd_z || upd_ar) begin
                z_ff <= (res == 8'h00);
            end
            if (upd_ar) begin
                c_ff <= alu[8];
                hc_ff <= alu[9];
                sov_ff <= alu[10];
            end else begin
                c_ff <= c_new;
            end
        end
    end

    // ****************************************
    // program counter and stack
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_ff <= `MEC_RST_PC;
            sp_ff <= 3'h0;
        end else if (ex) begin
            pc_ff <= nxt_pc;
            if (push) begin
                sp_ff <= sp_ff + 3'h1;
            end else if (pop) begin
                sp_ff <= sp_ff - 3'h1;
            end
        end
    end

    // stack wraps silently when nested too deep
    always_ff @(posedge clk_sys_i) begin
        if (ex && push) begin
            stk_ff[sp_ff] <= pc_ff + 11'h001;
        end
    end

    // ****************************************
    // memory ports
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pad_ff <= `MEC_RST_PC;
            dwd_ff <= `MEC_RST_BYTE;
            dwe_ff <= 1'b0;
            tblh_ff <= `MEC_RST_BYTE;
        end else begin
            dwe_ff <= (ex && wr_m && !pc_low_hit) || tload;
            if (ex) begin
                pad_ff <= tbl ? {`MEC_TBL_PAGE, acc_ff} : nxt_pc;
                dwd_ff <= res;
            end else if (tload) begin
                pad_ff <= pc_ff;
                dwd_ff <= pmem_data_i[7:0];
                tblh_ff <= pmem_data_i[15:8];
            end
        end
    end

    // ****************************************
    // watchdog and power-down flags
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            to_ff <= 1'b0;
            pdf_ff <= 1'b0;
            pre_ff <= 2'h0;
            wclr_ff <= 1'b0;
        end else begin
            wclr_ff <= ex && wclr;
            if (ex) begin
                pre_ff <= {w2, w1};
            end
            // a timeout in the clearing cycle still lands
            if (wdt_timeout_i) begin
                to_ff <= 1'b1;
            end else if (ex && (halt || wclr)) begin
                to_ff <= 1'b0;
            end
            if (ex && halt) begin
                pdf_ff <= 1'b1;
            end else if (ex && wclr) begin
                pdf_ff <= 1'b0;
            end
        end
    end

    assign pmem_addr_o = pad_ff;
    assign dmem_addr_o = dad_ff;
    assign dmem_wdata_o = dwd_ff;
    assign dmem_we_o = dwe_ff;
    assign acc_o = acc_ff;
    assign zero_flag_o = z_ff;
    assign carry_flag_o = c_ff;
    assign half_carry_flag_o = hc_ff;
    assign signed_range_exceed_flag_o = sov_ff;
    assign table_high_o = tblh_ff;
    assign power_down_o = st_ff[2];
    assign wdt_clear_o = wclr_ff;
    assign timeout_flag_o = to_ff;
    assign power_down_flag_o = pdf_ff;

    // ****************************************
    // checks
    // ****************************************
    logic [8:0] chk_sum;
    logic [7:0] rot_exp;
    assign chk_sum = {1'b0, acc_ff} + {1'b0, md_ff};
    assign rot_exp = {md_ff[0], md_ff[7:1]};
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_extra4;
        (st_ff == mec_pkg::st_extra) [*4] ##1 (st_ff == mec_pkg::st_run);
    endsequence
    cycle_len_a: assert property (
        ex && !halt |=> (!ex) [*3] ##1 (ex || st_ff != mec_pkg::st_run))
        else $error("instruction cycle not four clocks");
    branch_two_a: assert property (
        ex && (jump || pop || tbl) |=> s_extra4)
        else $error("branch did not take two cycles");
    pc_low_a: assert property (
        ex && pc_low_hit |=> pc_ff[7:0] == $past(res) && !dmem_we_o
            && st_ff == mec_pkg::st_extra)
        else $error("pc low write did not jump");
    skip_taken_a: assert property (
        ex && skip |=> pc_ff == $past(pc_ff) + 11'h002 ##0 s_extra4)
        else $error("taken skip wrong");
    skip_none_a: assert property (
        ex && !skip && (op == mec_pkg::op_skip_bit_set) |-> ##4 ex)
        else $error("untaken skip took extra cycle");
    call_save_a: assert property (
        ex && push |=> stk_top == $past(pc_ff) + 11'h001)
        else $error("call saved wrong return point");
    add_carry_a: assert property (
        ex && op == mec_pkg::op_add && !imm && !dst_m
            |=> {c_ff, acc_ff} == $past(chk_sum))
        else $error("add result or carry wrong");
    logic_flags_a: assert property (
        ex && (op == mec_pkg::op_and || op == mec_pkg::op_xor)
            |=> c_ff == $past(c_ff) && hc_ff == $past(hc_ff) && sov_ff == $past(sov_ff))
        else $error("logic op changed arithmetic flags");
    rotate_a: assert property (
        ex && op == mec_pkg::op_rot_right && !dst_m
            |=> acc_ff == $past(rot_exp) && c_ff == $past(c_ff) && z_ff == $past(z_ff))
        else $error("rotate right wrong");
    wdt_pair_a: assert property (
        ex && w2 && pre_ff[0] && !wdt_timeout_i
            |=> !to_ff && !pdf_ff && wdt_clear_o ##1 !wdt_clear_o)
        else $error("pre-clear pair did not clear flags");
endmodule
`default_nettype wire

// ==== testbench/mec_mem_model.sv ====
// program and data memory standing beside the execution core
// assumes combinational reads and one write per clock edge on clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module mec_mem_model (
    input wire logic clk_sys_i,
    input wire logic [10:0] pmem_addr_i,
    output logic [15:0] pmem_data_o,
    input wire logic [7:0] dmem_addr_i,
    output logic [7:0] dmem_rdata_o,
    input wire logic [7:0] dmem_wdata_i,
    input wire logic dmem_we_i
);
    // ****************
    // storage
    // ****************
    logic [15:0] prog [0:2047];
    logic [7:0] data [0:255];
    initial begin
        for (int i = 0; i < 2048; i++) begin
            prog[i] = 16'h0000;
        end
        for (int i = 0; i < 256; i++) begin
            data[i] = 8'h00;
        end
    end
    // unwritten words read as nop, so a stray fetch is harmless
    assign pmem_data_o = prog[pmem_addr_i];
    assign dmem_rdata_o = data[dmem_addr_i];
    always @(posedge clk_sys_i) begin
        if (dmem_we_i === 1'b1) begin
            data[dmem_addr_i] <= dmem_wdata_i;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/mec_core_test.sv ====
// self-checking bench of the execution core, one instruction at a time
// assumes the core fetches every fourth clock from address 0 after reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module mec_core_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wake = 1'b0;
    logic wdt_to = 1'b0;
    logic [10:0] paddr;
    logic [15:0] pdata;
    logic [7:0] daddr, drd, dwd, acc, thi;
    logic dwe, zf, cf, hf, of, pd, wclr, tof, pdf;
    int errors = 0;
    int n_tests = 0;
    int clears = 0;
    logic [10:0] pc = 11'h000;
    always #50 clk = ~clk;
    mec_core dut (.clk_sys_i(clk), .rst_n_i(rst_n), .pmem_addr_o(paddr), .pmem_data_i(pdata),
        .dmem_addr_o(daddr), .dmem_rdata_i(drd), .dmem_wdata_o(dwd), .dmem_we_o(dwe),
        .acc_o(acc), .zero_flag_o(zf), .carry_flag_o(cf), .half_carry_flag_o(hf),
        .signed_range_exceed_flag_o(of), .table_high_o(thi), .power_down_o(pd),
        .wake_i(wake), .wdt_timeout_i(wdt_to), .wdt_clear_o(wclr), .timeout_flag_o(tof),
        .power_down_flag_o(pdf));
    mec_mem_model u_mem (.clk_sys_i(clk), .pmem_addr_i(paddr), .pmem_data_o(pdata),
        .dmem_addr_i(daddr), .dmem_rdata_o(drd), .dmem_wdata_i(dwd), .dmem_we_i(dwe));
    always @(posedge clk) begin
        if (wclr === 1'b1) begin
            clears++;
        end
    end
    // ****************
    // access tasks
    // ****************
    task automatic tally_and_finish;
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // places a word at pc, lets n instruction cycles pass, checks the next fetch
    task automatic run(input logic [4:0] op, input logic [10:0] f, input int n,
        input logic [10:0] nxt);
        u_mem.prog[pc] = {op, f};
        repeat (4 * n) @(posedge clk);
        #1;
        `CHK(paddr, nxt)
        pc = nxt;
    endtask
    task automatic step(input logic [4:0] op, input logic [10:0] f);
        run(op, f, 1, pc + 11'h1);
    endtask
    // ****************
    // tests
    // ****************
    initial begin
        repeat (10) @(posedge clk);
        #1;
        u_mem.data[8'h21] = 8'hc8;
        u_mem.data[8'h22] = 8'hff;
        u_mem.data[8'h23] = 8'h80;
        u_mem.data[8'h25] = 8'hff;
        u_mem.prog[11'h705] = 16'hbeef;
        rst_n = 1'b1;
        step(mec_pkg::op_xfer_imm, 11'h23c);
        `CHK(acc, 8'h3c)
        step(mec_pkg::op_xfer_to_mem, 11'h120);
        `CHK(u_mem.data[8'h20], 8'h3c)
        step(mec_pkg::op_add, 11'h021);
        `CHK({acc, zf, cf, hf, of}, {8'h04, 4'b0110})
        step(mec_pkg::op_add_carry, 11'h121);
        `CHK({u_mem.data[8'h21], acc, cf, hf}, {16'hcd04, 2'b00})
        step(mec_pkg::op_subtract, 11'h284);
        `CHK({acc, zf, cf, hf, of}, {8'h80, 4'b0011})
        step(mec_pkg::op_sub_borrow, 11'h200);
        `CHK({acc, cf, of}, {8'h7f, 2'b11})
        step(mec_pkg::op_xor, 11'h27f);
        `CHK({acc, zf, cf, of}, {8'h00, 3'b111})
        step(mec_pkg::op_or, 11'h020);
        step(mec_pkg::op_and, 11'h121);
        `CHK({u_mem.data[8'h21], acc, zf, cf}, {16'h0c3c, 2'b01})
        step(mec_pkg::op_complement, 11'h021);
        `CHK({acc, zf, cf}, {8'hf3, 2'b01})
        step(mec_pkg::op_plus_one, 11'h022);
        `CHK({acc, zf, cf}, {8'h00, 2'b11})
        step(mec_pkg::op_minus_one, 11'h122);
        `CHK({u_mem.data[8'h22], zf}, {8'hfe, 1'b0})
        step(mec_pkg::op_rot_left, 11'h023);
        `CHK({acc, zf, cf}, {8'h01, 2'b01})
        step(mec_pkg::op_rot_right_c, 11'h023);
        `CHK({acc, cf, zf}, {8'hc0, 2'b00})
        step(mec_pkg::op_rot_right, 11'h123);
        step(mec_pkg::op_rot_left_c, 11'h123);
        `CHK({u_mem.data[8'h23], cf}, {8'h80, 1'b0})
        step(mec_pkg::op_bit_set, 11'h324);
        step(mec_pkg::op_bit_clear, 11'h725);
        `CHK({u_mem.data[8'h24], u_mem.data[8'h25]}, 16'h087f)
        run(mec_pkg::op_skip_bit_zero, 11'h224, 2, pc + 11'h2);
        run(mec_pkg::op_skip_bit_set, 11'h024, 1, pc + 11'h1);
        run(mec_pkg::op_skip_zero, 11'h126, 2, pc + 11'h2);
        `CHK(acc, 8'h00)
        step(mec_pkg::op_xfer_imm, 11'h215);
        step(mec_pkg::op_add, 11'h227);
        step(mec_pkg::op_dec_adjust, 11'h128);
        `CHK({u_mem.data[8'h28], cf, zf}, {8'h42, 2'b00})
        step(mec_pkg::op_xfer_to_acc, 11'h028);
        `CHK(acc, 8'h42)
        step(mec_pkg::op_subtract, 11'h128);
        `CHK({u_mem.data[8'h28], zf, cf, hf, of}, {8'h00, 4'b1110})
        step(mec_pkg::op_xfer_imm, 11'h205);
        run(mec_pkg::op_table_read, 11'h127, 2, pc + 11'h1);
        `CHK({u_mem.data[8'h27], thi}, 16'hefbe)
        step(mec_pkg::op_xfer_imm, 11'h240);
        run(mec_pkg::op_xfer_to_mem, 11'h106, 2, 11'h040);
        `CHK(u_mem.data[8'h06], 8'h00)
        run(mec_pkg::op_jump, 11'h010, 2, 11'h010);
        run(mec_pkg::op_call, 11'h100, 2, 11'h100);
        run(mec_pkg::op_return, 11'h000, 2, 11'h011);
        // second pass wakes on timeout and clears with the single instruction
        for (int k = 0; k < 2; k++) begin
            step(mec_pkg::op_misc, 11'h000);
            `CHK({pd, pdf, tof}, 3'b110)
            if (k == 0) begin
                wake = 1'b1;
            end else begin
                wdt_to = 1'b1;
            end
            @(posedge clk);
            #1;
            wake = 1'b0;
            wdt_to = 1'b0;
            if (k == 0) begin
                step(mec_pkg::op_misc, 11'h002);
                `CHK({pd, pdf}, 2'b01)
                step(mec_pkg::op_misc, 11'h003);
            end else begin
                `CHK({pd, tof}, 2'b01)
                step(mec_pkg::op_misc, 11'h001);
            end
            `CHK({pd, pdf, tof}, 3'b000)
        end
        `CHK(clears, 2)
        tally_and_finish;
    end
    // the sequence needs about 190 clocks
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        tally_and_finish;
    end
endmodule
`undef CHK
`default_nettype wire
